// ==== shared/spi_port_pkg.sv ====
// constants and types shared by the serial peripheral port
package spi_port_pkg;

  // ****************************************
  // register addresses on the sfr port
  // ****************************************
  localparam logic [7:0] CTL_ADDR = 8'hf8;  // serial_port_control
  localparam logic [7:0] CFG_ADDR = 8'he1;  // port_configuration_register
  localparam logic [7:0] CKR_ADDR = 8'he2;  // clock_rate_register
  localparam logic [7:0] DAT_ADDR = 8'he3;  // data register

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] CKR_RST  = 8'h00;
  localparam logic [7:0] DAT_RST  = 8'h00;
  localparam int         PHA_BIT  = 7;      // clock_phase_bit
  localparam int         POL_BIT  = 6;      // clock_polarity_bit
  localparam logic [5:0] CFG_RSVD = 6'h00;  // reserved bits read zero

  // ****************************************
  // frame timing counts
  // ****************************************
  localparam logic [3:0] BITS_PER_FRAME  = 4'h8;
  localparam logic [4:0] EDGES_PER_FRAME = 5'h10;
  localparam int         SYNC_STAGES_W   = 4;   // pins through synchroniser

  // control register layout, bit 7 first
  typedef struct packed {
    logic transfer_complete_flag;    // transfer_complete_flag
    logic write_collision_flag;    // write_collision_flag
    logic mode_fault_flag;    // mode_fault_flag
    logic receive_overrun_flag;  // receive_overrun_flag
    logic transmit_busy_flag;   // transmit_busy_flag
    logic slave_selected_flag;  // slave_selected_flag
    logic master_enable_bit;   // master_enable_bit
    logic port_enable_bit;   // port_enable_bit
  } ctl_t;

  // configuration register layout
  typedef struct packed {
    logic       pha;   // clock_phase_bit
    logic       pol;   // clock_polarity_bit
    logic [5:0] rsvd;
  } cfg_t;

  // one sfr access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef enum logic [0:0] {M_IDLE, M_RUN} mst_state_t;

endpackage : spi_port_pkg

// ==== rtl/pin_sync.sv ====
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk_in,  // core clock
  input  wire logic         nrst_in,      // async reset, low
  input  wire logic [W-1:0] d_in,         // raw pin levels
  output logic      [W-1:0] q_out         // synchronised levels
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : pin_sync

// ==== rtl/spi_port.sv ====
// serial peripheral port, master or slave, with sfr registers
// Overview of operation
// - mode fault clears master and port enable
// - phase bit picks the latching clock edge
// - polarity bit picks idle level of clock
// - both ends share one phase and polarity
// - clock rate register sets master clock frequency
// - slave ignores rate, follows incoming clock
// - complete flag interrupts, cleared only by software
`timescale 1ns/100ps
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic     core_clk_in,     // core clock, 25 MHz
  input  wire logic     nrst_in,         // async reset, low
  input  wire sfr_req_t sfr_req_in,      // sfr access
  output logic [7:0]    sfr_rdata_out,   // read data, cycle after rd
  input  wire logic     sclk_in,         // serial clock pin level
  output logic          sclk_out,        // serial clock drive
  output logic          sclk_oe_out,     // serial clock enable
  input  wire logic     mosi_in,         // master-out pin level
  output logic          mosi_out,        // master-out drive
  output logic          mosi_oe_out,     // master-out enable
  input  wire logic     miso_in,         // master-in pin level
  output logic          miso_out,        // master-in drive
  output logic          miso_oe_out,     // master-in enable
  input  wire logic     slave_select_n_in, // slave select, low
  output logic          irq_out          // port interrupt, high
);

  // ****************************************
  // pin synchronisers and decode
  // ****************************************
  logic [3:0] pin_s;
  logic       sclk_s, mosi_s, miso_s, nss_s;
  ctl_t       ctl_r, ctl_nxt;
  cfg_t       cfg_r;
  logic [7:0] ckr_r, shift_r, rx_buf_r, div_cnt_r;
  logic [4:0] edge_cnt_r;
  logic [3:0] slv_cnt_r;
  logic       rx_full_r, sclk_d_r;
  mst_state_t state_r;

  pin_sync #(.W(SYNC_STAGES_W)) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .d_in        ({sclk_in, mosi_in, miso_in, slave_select_n_in}),
    .q_out       (pin_s)
  );
  assign {sclk_s, mosi_s, miso_s, nss_s} = pin_s;

  // address match on a strobe
  function automatic logic hit(input sfr_req_t q, input logic [7:0] a,
                               input logic strobe);
    hit = strobe && (q.addr == a);
  endfunction : hit

  logic wr_ctl, wr_cfg, wr_ckr, wr_dat, rd_dat;
  assign wr_ctl = hit(sfr_req_in, CTL_ADDR, sfr_req_in.wr);
  assign wr_cfg = hit(sfr_req_in, CFG_ADDR, sfr_req_in.wr);
  assign wr_ckr = hit(sfr_req_in, CKR_ADDR, sfr_req_in.wr);
  assign wr_dat = hit(sfr_req_in, DAT_ADDR, sfr_req_in.wr);
  assign rd_dat = hit(sfr_req_in, DAT_ADDR, sfr_req_in.rd);

  // ****************************************
  // edge classification
  // ****************************************
  logic m_tick, m_lead, m_sample, m_shout, m_done, mode_fault;
  logic slave_act, s_edge, s_lead, s_sample, s_shout, s_done;
  logic in_bit, sample_now, xfer_done, start, collide;
  logic [7:0] shift_in;

  assign m_tick   = (state_r == M_RUN) && (div_cnt_r == ckr_r);
  assign m_lead   = (sclk_out == cfg_r.pol);
  assign m_sample = m_tick && (m_lead ^ cfg_r.pha);
  assign m_shout  = m_tick && !(m_lead ^ cfg_r.pha);
  assign m_done   = m_tick && (edge_cnt_r == EDGES_PER_FRAME - 5'h01);
  assign mode_fault = ctl_r.master_enable_bit && !nss_s;

  assign slave_act = ctl_r.port_enable_bit && !ctl_r.master_enable_bit && !nss_s;
  assign s_edge    = slave_act && (sclk_s != sclk_d_r);
  // slave uses same phase and polarity
  assign s_lead    = s_edge && (sclk_d_r == cfg_r.pol);
  assign s_sample  = s_edge && (s_lead ^ cfg_r.pha);
  assign s_shout   = s_edge && !(s_lead ^ cfg_r.pha);
  assign s_done    = s_sample && (slv_cnt_r == BITS_PER_FRAME - 4'h1);

  assign in_bit     = ctl_r.master_enable_bit ? miso_s : mosi_s;
  assign sample_now = m_sample || s_sample;
  assign shift_in   = {shift_r[6:0], in_bit};
  assign xfer_done  = m_done || s_done;
  assign start      = wr_dat && ctl_r.master_enable_bit && ctl_r.port_enable_bit &&
                      (state_r == M_IDLE) && !mode_fault;
  assign collide    = wr_dat && ((state_r == M_RUN) ||
                      (slave_act && (slv_cnt_r != 4'h0)));

  // ****************************************
  // control register
  // ****************************************
  // next control value, hardware sets win over writes
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt.transfer_complete_flag   = sfr_req_in.wdata[7];
      ctl_nxt.write_collision_flag   = sfr_req_in.wdata[6];
      ctl_nxt.mode_fault_flag   = sfr_req_in.wdata[5];
      ctl_nxt.receive_overrun_flag = sfr_req_in.wdata[4];
      ctl_nxt.master_enable_bit  = sfr_req_in.wdata[1];
      ctl_nxt.port_enable_bit  = sfr_req_in.wdata[0];
    end
    if (xfer_done) ctl_nxt.transfer_complete_flag = 1'b1;
    if (collide) ctl_nxt.write_collision_flag = 1'b1;
    if (xfer_done && rx_full_r && !rd_dat) ctl_nxt.receive_overrun_flag = 1'b1;
    if (mode_fault) begin
      ctl_nxt.mode_fault_flag  = 1'b1;
      ctl_nxt.master_enable_bit = 1'b0;
      ctl_nxt.port_enable_bit = 1'b0;
    end
    ctl_nxt.transmit_busy_flag  = start ||
                     ((state_r == M_RUN) && !m_done && !mode_fault);
    ctl_nxt.slave_selected_flag = !nss_s;
  end

  // control, configuration and rate registers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_r <= ctl_t'(CTL_RST);
      cfg_r <= cfg_t'(CFG_RST);
      ckr_r <= CKR_RST;
    end else begin
      ctl_r <= ctl_nxt;
      if (wr_cfg) begin
        cfg_r <= {sfr_req_in.wdata[PHA_BIT], sfr_req_in.wdata[POL_BIT],
                  CFG_RSVD};
      end
      if (wr_ckr) ckr_r <= sfr_req_in.wdata;
    end
  end

  // ****************************************
  // master sequencer and clock divider
  // ****************************************
  // master run state
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= M_IDLE;
    end else begin
      case (state_r)
        M_IDLE:  if (start) state_r <= M_RUN;
        M_RUN:   if (m_done || mode_fault) state_r <= M_IDLE;
        default: state_r <= M_IDLE;
      endcase
    end
  end

  // half-period divider and edge counter
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_r  <= 8'h00;
      edge_cnt_r <= 5'h00;
    end else begin
      if (state_r != M_RUN || m_tick) div_cnt_r <= 8'h00;
      else div_cnt_r <= div_cnt_r + 8'h01;
      if (state_r != M_RUN) edge_cnt_r <= 5'h00;
      else if (m_tick) edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  // master pin drive
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
      mosi_out    <= 1'b0;
      mosi_oe_out <= 1'b0;
    end else begin
      sclk_oe_out <= ctl_nxt.master_enable_bit && ctl_nxt.port_enable_bit;
      mosi_oe_out <= ctl_nxt.master_enable_bit && ctl_nxt.port_enable_bit;
      if (state_r != M_RUN || mode_fault) sclk_out <= cfg_r.pol;
      else if (m_tick) sclk_out <= !sclk_out;
      if (start) mosi_out <= sfr_req_in.wdata[7];
      else if (m_shout) mosi_out <= shift_r[7];
    end
  end

  // ****************************************
  // slave side and shift register
  // ****************************************
  // slave bit counter and clock history
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slv_cnt_r <= 4'h0;
      sclk_d_r  <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      if (!slave_act || s_done) slv_cnt_r <= 4'h0;
      else if (s_sample) slv_cnt_r <= slv_cnt_r + 4'h1;
    end
  end

  // shared shift register
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_r <= DAT_RST;
    end else if (wr_dat && !collide) begin
      shift_r <= sfr_req_in.wdata;
    end else if (sample_now) begin
      shift_r <= shift_in;
    end
  end

  // slave output pin
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      miso_oe_out <= slave_act;
      if (s_shout || slv_cnt_r == 4'h0) miso_out <= shift_r[7];
    end
  end

  // receive buffer, kept on overrun
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_buf_r  <= DAT_RST;
      rx_full_r <= 1'b0;
    end else if (xfer_done && (!rx_full_r || rd_dat)) begin
      // phase 0 master ends on a shift-out edge, no extra bit
      rx_buf_r  <= sample_now ? shift_in : shift_r;
      rx_full_r <= 1'b1;
    end else if (rd_dat) begin
      rx_full_r <= 1'b0;
    end
  end

  // ****************************************
  // read data and interrupt
  // ****************************************
  // registered read mux
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_req_in.rd) begin
      case (sfr_req_in.addr)
        CTL_ADDR: sfr_rdata_out <= ctl_r;
        CFG_ADDR: sfr_rdata_out <= cfg_r;
        CKR_ADDR: sfr_rdata_out <= ckr_r;
        DAT_ADDR: sfr_rdata_out <= rx_buf_r;
        default:  sfr_rdata_out <= 8'h00;
      endcase
    end else begin
      sfr_rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) irq_out <= 1'b0;
    else irq_out <= ctl_r.transfer_complete_flag || ctl_r.write_collision_flag || ctl_r.mode_fault_flag || ctl_r.receive_overrun_flag;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_fault_irq;
    mode_fault |=> ctl_r.mode_fault_flag ##1 irq_out;
  endproperty
  a_fault_irq: assert property (p_fault_irq)
    else $error("mode fault did not raise flag and irq");

  property p_offline;
    $rose(ctl_r.mode_fault_flag) && !$past(wr_ctl) |-> !ctl_r.master_enable_bit && !ctl_r.port_enable_bit;
  endproperty
  a_offline: assert property (p_offline)
    else $error("mode fault left port enabled");

  property p_sample_edge;
    m_sample && !wr_dat |=> shift_r[0] == $past(miso_s);
  endproperty
  a_sample_edge: assert property (p_sample_edge)
    else $error("master sampled on wrong edge");

  property p_idle_level;
    state_r == M_IDLE ##1 state_r == M_IDLE |-> sclk_out == $past(cfg_r.pol);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle clock level not polarity");

  property p_slave_drive;
    miso_oe_out |-> $past(slave_act) && !ctl_r.master_enable_bit && !$past(nss_s);
  endproperty
  a_slave_drive: assert property (p_slave_drive)
    else $error("slave drove output while not selected");

  property p_rate;
    state_r == M_RUN && !m_tick && !mode_fault |=> $stable(sclk_out);
  endproperty
  a_rate: assert property (p_rate)
    else $error("master clock toggled before divider end");

  property p_slave_no_div;
    !ctl_r.master_enable_bit |=> div_cnt_r == 8'h00 && state_r == M_IDLE;
  endproperty
  a_slave_no_div: assert property (p_slave_no_div)
    else $error("divider ran in slave mode");

  property p_transfer_complete_flag_sticky;
    ctl_r.transfer_complete_flag && !wr_ctl |=> ctl_r.transfer_complete_flag;
  endproperty
  a_transfer_complete_flag_sticky: assert property (p_transfer_complete_flag_sticky)
    else $error("complete flag cleared without software");

  property p_overrun;
    xfer_done && rx_full_r && !rd_dat |=> ctl_r.receive_overrun_flag ##1 irq_out;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_busy_end;
    m_done && !mode_fault |=> !ctl_r.transmit_busy_flag && ctl_r.transfer_complete_flag;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy flag not cleared at transfer end");

  property p_busy_start;
    start |=> ctl_r.transmit_busy_flag && state_r == M_RUN;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy flag not set on start");

  c_master: cover property (m_done);
  c_slave:  cover property (s_done);
  c_fault:  cover property (mode_fault ##1 ctl_r.mode_fault_flag);
  c_ovr:    cover property (xfer_done && rx_full_r);

endmodule : spi_port

// ==== tb/spi_far_slave.sv ====
// behavioural serial slave answering the port in master mode
`timescale 1ns/100ps
module spi_far_slave (
  input  wire logic sclk_in,  // serial clock wire
  input  wire logic mosi_in,  // data from master
  input  wire logic pol_in,   // idle clock level
  input  wire logic pha_in,   // latching edge select
  output logic      miso_out  // data to master
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  int         cnt = 8;
  // arm one frame of reply data
  task automatic load(input logic [7:0] tx);
    cnt = 0;
    sh = pha_in ? tx : {tx[6:0], 1'b0};
    miso_out = pha_in ? ~tx[7] : tx[7];
  endtask : load
  initial miso_out = 1'b0;
  always @(sclk_in) begin
    if (cnt < 8) begin
      if ((sclk_in != pol_in) ^ pha_in) begin
        rx = {rx[6:0], mosi_in};
        cnt = cnt + 1;
      end else begin
        miso_out = sh[7];
        sh = {sh[6:0], 1'b0};
      end
    end else begin
      miso_out = ~miso_out;  // frame over, toggles each edge, no stale level
    end
  end
endmodule : spi_far_slave

// ==== tb/tb.sv ====
// self-checking bench for the serial peripheral port
`timescale 1ns/100ps
module tb;
  import spi_port_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  sfr_req_t   req = '0;
  logic [7:0] rdata, d, tx, rxb, got;
  logic       sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq;
  logic       sclk_m = 1'b0, mosi_m = 1'b0, ssn = 1'b1, far_miso;
  logic       pol = 1'b0, pha = 1'b0;
  wire        sclk_w = sclk_oe ? sclk_o : sclk_m;
  wire        mosi_w = mosi_oe ? mosi_o : mosi_m;
  wire        miso_w = miso_oe ? miso_o : far_miso;
  int         fails = 0, check_count = 0, seed = 32'hb8f83642, ckr;
  logic [7:0] adrs [5] = '{CTL_ADDR, CFG_ADDR, CKR_ADDR, DAT_ADDR, 8'h00};
  logic [7:0] rsts [5] = '{CTL_RST, CFG_RST, CKR_RST, DAT_RST, 8'h00};

  always #20 core_clk_in = ~core_clk_in;

  spi_port uut (
    .core_clk_in (core_clk_in), .nrst_in (nrst_in), .sfr_req_in (req),
    .sfr_rdata_out (rdata), .sclk_in (sclk_w), .sclk_out (sclk_o),
    .sclk_oe_out (sclk_oe), .mosi_in (mosi_w), .mosi_out (mosi_o),
    .mosi_oe_out (mosi_oe), .miso_in (miso_w), .miso_out (miso_o),
    .miso_oe_out (miso_oe), .slave_select_n_in (ssn), .irq_out (irq)
  );
  spi_far_slave partner (
    .sclk_in (sclk_w), .mosi_in (mosi_w), .pol_in (pol), .pha_in (pha),
    .miso_out (far_miso)
  );

  // ****************************************
  // bus and check helpers
  // ****************************************
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick();
    @(posedge core_clk_in) #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, v);
    @(posedge core_clk_in) req <= '{addr:a, wdata:v, wr:1'b1, rd:1'b0};
    @(posedge core_clk_in) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_in) req <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
    @(posedge core_clk_in) req <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) tick();
    if (irq !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_irq
  // one master frame, half period measured on the wire
  task automatic master_xfer(input logic [7:0] txv, slv, ectl,
                             input bit col);
    logic s;
    int   n;
    partner.load(slv);
    wr(DAT_ADDR, txv);
    rd(CTL_ADDR, d);
    chk("transmit_busy_flag", 8'h08, d & 8'h08);
    s = sclk_o;
    for (n = 0; n < 64 && sclk_o === s; n++) tick();
    s = sclk_o;
    for (n = 0; n < 64 && sclk_o === s; n++) tick();
    chk("half", 8'(ckr + 1), 8'(n));
    // collision lands mid-frame, after the rate measurement
    if (col) wr(DAT_ADDR, 8'hff);
    // poll complete flag, irq may already stand for a collision
    for (n = 0; n < 200 && d[7] !== 1'b1; n++) rd(CTL_ADDR, d);
    if (d[7] !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    chk("ctl", ectl, d);
    tick();
    chk("irq set", 8'h01, {7'h00, irq});
    chk("far rx", txv, partner.rx);
  endtask : master_xfer

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (3) tick();
    for (int i = 0; i < 5; i++) begin
      rd(adrs[i], d);
      chk("reset", rsts[i], d);
    end
    wr(8'h00, 8'hff);
    rd(8'h00, d);
    chk("unmapped", 8'h00, d);
    wr(CFG_ADDR, 8'hff);
    rd(CFG_ADDR, d);
    chk("cfg", 8'hc0, d);
    wr(CTL_ADDR, 8'h0c);
    rd(CTL_ADDR, d);
    chk("ctl ro", 8'h00, d);
    // all four clock modes, random rate and data
    for (int m = 0; m < 4; m++) begin
      pha = m[1];
      pol = m[0];
      ckr = 3 + ($random(seed) & 3);
      tx = $random(seed);
      rxb = $random(seed);
      rd(CTL_ADDR, d);
      chk("slave_selected_flag", 8'h00, d & 8'h04);
      wr(CTL_ADDR, 8'h00);
      wr(CFG_ADDR, {pha, pol, 6'h00});
      wr(CKR_ADDR, ckr[7:0]);
      wr(CTL_ADDR, 8'h03);
      tick();
      chk("idle", {7'h00, pol}, {7'h00, sclk_o});
      master_xfer(tx, rxb, 8'h83, 1'b0);
      rd(DAT_ADDR, d);
      chk("rx", rxb, d);
      wr(CTL_ADDR, 8'h03);
      tick();
      tick();
      chk("irq", 8'h00, {7'h00, irq});
    end
    // unread byte overrun plus collision mid-frame
    master_xfer(8'h5a, 8'ha5, 8'h83, 1'b0);
    // clear complete flag, leave the byte unread
    wr(CTL_ADDR, 8'h03);
    master_xfer(8'h3c, 8'h96, 8'hd3, 1'b1);
    rd(DAT_ADDR, d);
    chk("kept", 8'ha5, d);
    // slave frame with a rate value that must not matter
    tx = $random(seed);
    rxb = $random(seed);
    wr(CTL_ADDR, 8'h00);
    wr(CFG_ADDR, 8'h00);
    wr(CKR_ADDR, 8'hff);
    wr(CTL_ADDR, 8'h01);
    wr(DAT_ADDR, tx);
    @(posedge core_clk_in) ssn <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    for (int b = 7; b >= 0; b--) begin
      @(posedge core_clk_in);
      sclk_m <= 1'b0;
      mosi_m <= rxb[b];
      repeat (4) @(posedge core_clk_in);
      got[b] = miso_w;
      sclk_m <= 1'b1;
      repeat (3) @(posedge core_clk_in);
    end
    @(posedge core_clk_in);
    sclk_m <= 1'b0;
    mosi_m <= ~mosi_m;
    wait_irq();
    rd(CTL_ADDR, d);
    chk("slave ctl", 8'h85, d);
    chk("slave tx", tx, got);
    rd(DAT_ADDR, d);
    chk("slave rx", rxb, d);
    @(posedge core_clk_in) ssn <= 1'b1;
    wr(CTL_ADDR, 8'h00);
    // another master pulls select low
    repeat (3) tick();
    wr(CTL_ADDR, 8'h03);
    @(posedge core_clk_in) ssn <= 1'b0;
    wait_irq();
    rd(CTL_ADDR, d);
    chk("fault ctl", 8'h24, d);
    chk("fault oe", 8'h00, {7'h00, sclk_oe});
    @(posedge core_clk_in) ssn <= 1'b1;
    tally_and_finish();
  end
endmodule : tb
